// >>> logic/eepc_pkg.sv
// Shared constants and types for the nonvolatile program/erase controller.
`default_nettype none
package eepc_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [15:0] IDX_BLOCK_PROTECT = 16'h1035;
    localparam logic [15:0] IDX_PUMP_CTL      = 16'h1039;
    localparam logic [15:0] IDX_NVM_PROGRAM   = 16'h103b;
    localparam logic [15:0] IDX_OPTION_CELL   = 16'h103f;
    // The array fills the top 512 offsets of a 4-Kbyte page.
    localparam logic [2:0]  ARRAY_TOP_BITS    = 3'h7;
    localparam logic [3:0]  FORCED_PAGE       = 4'hf;
    localparam int          ARRAY_BYTES       = 512;
    // Block boundaries inside the array.
    localparam int          BLK1_START        = 32'h020;
    localparam int          BLK2_START        = 32'h060;
    localparam int          BLK3_START        = 32'h0e0;
    localparam int          ROW_LSB           = 4;
    // Field positions.
    localparam int          BP_OPT_BIT        = 4;
    localparam int          CFG_PAGE_LSB      = 4;
    localparam int          CFG_EN_BIT        = 0;
    localparam int          PUMP_PUMP_RC_CLOCK_SELECT_BIT     = 6;
    // Reset values.
    localparam logic [4:0]  BLOCK_PROTECT_CTL_RESET       = 5'h1f;
    localparam logic [7:0]  NVM_PROGRAM_CTL_RESET       = 8'h00;
    localparam logic [7:0]  CFG_RESET         = 8'hff;
    localparam logic [7:0]  ERASED_BYTE       = 8'hff;
    // Cycles after reset in which protect bits may still be cleared.
    localparam int          PROT_WINDOW_CYC   = 64;

    typedef struct packed {
        logic odd;
        logic even;
        logic rsv;
        logic byte_sel;
        logic row_sel;
        logic erase;
        logic latch_bit;
        logic high_voltage_bit;
    } eepc_nvm_program_ctl_t;

    typedef struct packed {
        logic       opt;
        logic [8:0] off;
        logic [7:0] data;
    } eepc_op_t;

    typedef struct packed {
        logic [15:0] idx;
        logic        wr;
    } eepc_dphase_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WRITE   = 2'b01,
        ST_RD_WAIT = 2'b10,
        ST_RD_DONE = 2'b11
    } eepc_bus_st_t;
endpackage : eepc_pkg
`default_nettype wire

// >>> logic/eepc_ctrl.sv
// Program/erase controller for the 512-byte array and option cell.
`timescale 1ns/1ns
`default_nettype none
module eepc_ctrl
    import eepc_pkg::*;
#(
    parameter int         PROT_WINDOW = PROT_WINDOW_CYC,
    parameter logic [7:0] OPT_INIT    = CFG_RESET
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Mode pins
    input  wire logic        single_chip_mode,
    input  wire logic        special_mode,
    // Charge pump control
    output logic             hv_on,
    output logic             erase_mode,
    output logic             pump_rc_clock_select
);

    if (PROT_WINDOW < 1 || PROT_WINDOW > 127) begin : g_bad_window
        $error("PROT_WINDOW must lie in 1..127");
    end

    eepc_bus_st_t st_ff;
    eepc_bus_st_t nxt_st;
    eepc_dphase_t dp_ff;
    eepc_nvm_program_ctl_t  pp_ff;
    eepc_op_t     op_ff;
    logic [4:0]   bp_ff;
    logic [6:0]   win_cnt_ff;
    logic         sc_meta_ff, sc_ff, sp_meta_ff, sp_ff;
    logic         seen_ff, fire_ff, pump_ff, cfg_loaded_ff;
    logic [7:0]   cfg_active_ff;
    logic [7:0]   opt_cell_ff = OPT_INIT;
    logic [7:0]   mem_ff [ARRAY_BYTES];
    logic [31:0]  hrdata_ff;
    logic         acc, wr_now, arr_hit, win_open, bulk;
    logic         latch_new, hv_new;
    logic [3:0]   page;
    logic [8:0]   off;
    logic [7:0]   rd_byte;

    // Mode pins come from outside the clock domain.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_meta_ff <= 1'b0;
            sc_ff      <= 1'b0;
            sp_meta_ff <= 1'b0;
            sp_ff      <= 1'b0;
        end else begin
            sc_meta_ff <= single_chip_mode;
            sc_ff      <= sc_meta_ff;
            sp_meta_ff <= special_mode;
            sp_ff      <= sp_meta_ff;
        end
    end

    // Bus state machine; reads take one wait state so that a write in the
    // preceding data phase is always visible to the read.
    assign acc    = hsel && htrans[1] && hready;
    assign wr_now = (st_ff == ST_WRITE);

    always_comb begin
        case (st_ff)
            ST_RD_WAIT: nxt_st = ST_RD_DONE;
            default:    nxt_st = acc ? (hwrite ? ST_WRITE : ST_RD_WAIT)
                                     : ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            dp_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            if (acc) begin
                dp_ff <= '{idx: haddr[17:2], wr: hwrite};
            end
        end
    end

    assign hreadyout = (st_ff != ST_RD_WAIT);
    assign hresp     = 1'b0;

    // Option value is captured once after reset release and then held.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_loaded_ff <= 1'b0;
            cfg_active_ff <= CFG_RESET;
        end else if (!cfg_loaded_ff) begin
            cfg_loaded_ff <= 1'b1;
            cfg_active_ff <= opt_cell_ff;
        end
    end

    // Array placement in the index space.
    assign page    = sc_ff ? FORCED_PAGE
                           : cfg_active_ff[CFG_PAGE_LSB +: 4];
    assign arr_hit = (sc_ff || cfg_active_ff[CFG_EN_BIT])
                     && dp_ff.idx[15:12] == page
                     && dp_ff.idx[11:9] == ARRAY_TOP_BITS;
    assign off     = dp_ff.idx[8:0];

    // Protect window counter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_ff <= '0;
        end else if (win_open) begin
            win_cnt_ff <= win_cnt_ff + 7'h01;
        end
    end
    assign win_open = (win_cnt_ff < 7'(PROT_WINDOW));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_ff <= BLOCK_PROTECT_CTL_RESET;
        end else if (wr_now && dp_ff.idx == IDX_BLOCK_PROTECT) begin
            if (win_open || sp_ff) begin
                bp_ff <= hwdata[4:0];
            end else begin
                bp_ff <= bp_ff | hwdata[4:0];
            end
        end
    end

    // A combined latch and voltage write from latch clear sets neither.
    assign latch_new = hwdata[1] && (pp_ff.latch_bit || !hwdata[0]);
    assign hv_new    = hwdata[0] && pp_ff.latch_bit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pp_ff <= eepc_nvm_program_ctl_t'(NVM_PROGRAM_CTL_RESET);
        end else if (wr_now && dp_ff.idx == IDX_NVM_PROGRAM) begin
            pp_ff <= eepc_nvm_program_ctl_t'({hwdata[7:6], 1'b0, hwdata[4:2],
                                    latch_new, hv_new});
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_ff <= 1'b0;
        end else if (wr_now && dp_ff.idx == IDX_PUMP_CTL) begin
            pump_ff <= hwdata[PUMP_PUMP_RC_CLOCK_SELECT_BIT];
        end
    end

    // Latched target; only an array or option write in latch mode with the
    // voltage off counts, so runaway code cannot redirect a running cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff   <= '0;
            seen_ff <= 1'b0;
        end else if (!pp_ff.latch_bit) begin
            seen_ff <= 1'b0;
        end else if (wr_now && !pp_ff.high_voltage_bit
                     && (arr_hit || dp_ff.idx == IDX_OPTION_CELL)) begin
            op_ff   <= '{opt: !arr_hit, off: off,
                         data: hwdata[7:0]};
            seen_ff <= 1'b1;
        end
    end

    // One pulse when the voltage turns on over a latched target.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_ff <= 1'b0;
        end else begin
            fire_ff <= wr_now && dp_ff.idx == IDX_NVM_PROGRAM && hv_new
                       && !pp_ff.high_voltage_bit && seen_ff;
        end
    end

    assign bulk = pp_ff.erase && !pp_ff.byte_sel && !pp_ff.row_sel;

    // Cells are applied in one step; program can only clear bits.
    for (genvar i = 0; i < ARRAY_BYTES; i++) begin : g_cell
        localparam int BLK = (i < BLK1_START) ? 0 : (i < BLK2_START) ? 1
                           : (i < BLK3_START) ? 2 : 3;
        logic sel;
        always_comb begin
            if (bulk) begin
                sel = 1'b1;
            end else if (op_ff.opt) begin
                sel = 1'b0;
            end else if (pp_ff.erase && !pp_ff.byte_sel) begin
                sel = op_ff.off[8:ROW_LSB]
                      == 5'(i >> ROW_LSB);
            end else begin
                sel = op_ff.off == 9'(i);
            end
        end
        always_ff @(posedge clk) begin
            if (fire_ff && sel && !bp_ff[BLK]) begin
                mem_ff[i] <= pp_ff.erase ? ERASED_BYTE
                                         : (mem_ff[i] & op_ff.data);
            end
        end
    end

    // The option cell holds its value through reset.
    always_ff @(posedge clk) begin
        if (fire_ff && op_ff.opt && !bp_ff[BP_OPT_BIT]) begin
            opt_cell_ff <= pp_ff.erase ? ERASED_BYTE
                                       : (opt_cell_ff & op_ff.data);
        end
    end

    // Read mux; protection plays no part in reads.
    always_comb begin
        if (dp_ff.idx == IDX_BLOCK_PROTECT) begin
            rd_byte = {3'h0, bp_ff};
        end else if (dp_ff.idx == IDX_NVM_PROGRAM) begin
            rd_byte = pp_ff;
        end else if (dp_ff.idx == IDX_PUMP_CTL) begin
            rd_byte = 8'(pump_ff) << PUMP_PUMP_RC_CLOCK_SELECT_BIT;
        end else if (dp_ff.idx == IDX_OPTION_CELL) begin
            rd_byte = cfg_active_ff;
        end else if (arr_hit && !pp_ff.latch_bit) begin
            rd_byte = mem_ff[off];
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_ff <= '0;
        end else if (st_ff == ST_RD_WAIT) begin
            hrdata_ff <= {24'h000000, rd_byte};
        end
    end

    assign hrdata               = hrdata_ff;
    assign hv_on                = pp_ff.high_voltage_bit;
    assign erase_mode           = pp_ff.erase;
    assign pump_rc_clock_select = pump_ff;

    sequence s_rd_prog;
        acc && !hwrite && haddr[17:2] == IDX_NVM_PROGRAM;
    endsequence

    sequence s_opt_bulk;
        fire_ff && op_ff.opt && bulk && !bp_ff[BP_OPT_BIT] && !bp_ff[0];
    endsequence

    property p_bp_no_clear;
        @(posedge clk) disable iff (!rst_n)
        (!win_open && !sp_ff) |=> ((bp_ff & $past(bp_ff)) == $past(bp_ff));
    endproperty
    a_bp_no_clear: assert property (p_bp_no_clear)
        else $error("protect bit cleared after window");

    property p_both_first;
        @(posedge clk) disable iff (!rst_n)
        (wr_now && dp_ff.idx == IDX_NVM_PROGRAM && !pp_ff.latch_bit
         && hwdata[1:0] == 2'h3) |=> (!pp_ff.latch_bit
                                      && !pp_ff.high_voltage_bit);
    endproperty
    a_both_first: assert property (p_both_first)
        else $error("latch and voltage set together");

    property p_hv_needs_latch;
        @(posedge clk) disable iff (!rst_n)
        $rose(pp_ff.high_voltage_bit) |-> $past(pp_ff.latch_bit);
    endproperty
    a_hv_needs_latch: assert property (p_hv_needs_latch)
        else $error("voltage set without latch");

    property p_op_held;
        @(posedge clk) disable iff (!rst_n)
        (pp_ff.high_voltage_bit && $past(pp_ff.high_voltage_bit))
            |-> $stable(op_ff);
    endproperty
    a_op_held: assert property (p_op_held)
        else $error("latched target moved under voltage");

    property p_fire_needs_addr;
        @(posedge clk) disable iff (!rst_n)
        fire_ff |-> ($past(seen_ff) && pp_ff.high_voltage_bit);
    endproperty
    a_fire_needs_addr: assert property (p_fire_needs_addr)
        else $error("operation without latched address");

    property p_opt_protect;
        @(posedge clk) disable iff (!rst_n)
        (fire_ff && bp_ff[BP_OPT_BIT]) |=> $stable(opt_cell_ff);
    endproperty
    a_opt_protect: assert property (p_opt_protect)
        else $error("protected option cell changed");

    property p_opt_bulk;
        @(posedge clk) disable iff (!rst_n)
        s_opt_bulk |=> (opt_cell_ff == ERASED_BYTE
                        && mem_ff[0] == ERASED_BYTE);
    endproperty
    a_opt_bulk: assert property (p_opt_bulk)
        else $error("bulk erase at option cell incomplete");

    property p_rsv_zero;
        @(posedge clk) disable iff (!rst_n)
        s_rd_prog |-> ##1 !hreadyout ##1 (hreadyout && !hrdata[5]);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("control read bit 5 not zero");

    property p_cfg_hold;
        @(posedge clk) disable iff (!rst_n)
        (cfg_loaded_ff && $past(cfg_loaded_ff)) |-> $stable(cfg_active_ff);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("active option changed without reset");

endmodule : eepc_ctrl
`default_nettype wire

// >>> verif/eeprom_program_erase_ctrl_bench.sv
// Self-checking bench for the program/erase controller over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module eeprom_program_erase_ctrl_bench;
    import eepc_pkg::*;
    localparam int         WIN = PROT_WINDOW_CYC;
    localparam logic [15:0] CTL = IDX_NVM_PROGRAM;
    localparam logic [15:0] BP  = IDX_BLOCK_PROTECT;
    localparam logic [15:0] OPT = IDX_OPTION_CELL;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        single_chip_mode;
    logic        special_mode;
    logic        hv_on;
    logic        erase_mode;
    logic        pump_rc_clock_select;
    int          miscompares;
    int          total_checks;
    int          cyc;
    logic [8:0]  offs [7];

    eepc_ctrl #(.PROT_WINDOW(WIN), .OPT_INIT(CFG_RESET)) eepc_ctrl_inst (
        .clk                 (clk),
        .rst_n               (rst_n),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (3'h2),
        .hwdata              (hwdata),
        .hready              (hreadyout),
        .hreadyout           (hreadyout),
        .hresp               (hresp),
        .hrdata              (hrdata),
        .single_chip_mode    (single_chip_mode),
        .special_mode        (special_mode),
        .hv_on               (hv_on),
        .erase_mode          (erase_mode),
        .pump_rc_clock_select(pump_rc_clock_select)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cycles since the last reset release, to step past the protect window.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) cyc <= 0;
        else cyc <= cyc + 1;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk8

    task automatic chk1(string nm, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %b seen %b", nm, e, g);
            miscompares++;
        end
    endtask : chk1

    // The slave may stretch any phase; a stuck bus ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask : wait_ready

    task automatic ahb(logic w, logic [15:0] idx, logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {14'h0, idx, 2'h0};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        q = hrdata[7:0];
    endtask : ahb

    task automatic wr(logic [15:0] idx, logic [7:0] d);
        logic [7:0] q;
        ahb(1'b1, idx, d, q);
    endtask : wr

    task automatic rdc(string nm, logic [15:0] idx, logic [7:0] e);
        logic [7:0] q;
        ahb(1'b0, idx, 8'h00, q);
        chk8(nm, e, q);
        chk1("hresp", 1'b0, hresp);
    endtask : rdc

    function automatic logic [15:0] arr(logic [8:0] o);
        return {FORCED_PAGE, ARRAY_TOP_BITS, o};
    endfunction : arr

    // Full software sequence: latch, target, voltage on, voltage off, clear.
    task automatic op(logic [7:0] c, logic [15:0] idx, logic [7:0] d);
        wr(CTL, c);
        wr(idx, d);
        wr(CTL, c | 8'h01);
        @(negedge clk);
        chk1("hv_on", 1'b1, hv_on);
        chk1("erase_mode", c[2], erase_mode);
        wr(CTL, c);
        @(negedge clk);
        chk1("hv_off", 1'b0, hv_on);
        wr(CTL, 8'h00);
    endtask : op

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    initial begin
        miscompares = 0;
        total_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        single_chip_mode = 1'b1;
        special_mode = 1'b0;
        offs = '{9'h01f, 9'h020, 9'h05f, 9'h060, 9'h0df, 9'h0e0, 9'h1ff};
        do_reset();
        rdc("protect", BP, 8'(BLOCK_PROTECT_CTL_RESET));
        wr(BP, 8'h00);
        rdc("protect clr", BP, 8'h00);
        rdc("control", CTL, NVM_PROGRAM_CTL_RESET);
        rdc("option", OPT, CFG_RESET);
        wr(CTL, 8'h20);
        rdc("bit5", CTL, 8'h00);
        wr(CTL, 8'h01);
        rdc("hv no latch", CTL, 8'h00);
        wr(CTL, 8'h03);
        rdc("latch hv first", CTL, 8'h00);
        wr(CTL, 8'h06);
        rdc("erase latch", CTL, 8'h06);
        wr(CTL, 8'h00);
        wr(IDX_PUMP_CTL, 8'h40);
        @(negedge clk);
        chk1("pump clock", 1'b1, pump_rc_clock_select);
        wr(16'h1000, 8'h5a);
        rdc("unmapped", 16'h1000, 8'h00);
        $display("test registers done");
        op(8'h06, arr(9'h123), 8'h00);
        rdc("bulk lo", arr(9'h000), ERASED_BYTE);
        rdc("bulk hi", arr(9'h1ff), ERASED_BYTE);
        op(8'h02, arr(9'h045), 8'h5a);
        rdc("program", arr(9'h045), 8'h5a);
        op(8'h02, arr(9'h045), 8'h0f);
        rdc("program and", arr(9'h045), 8'h0a);
        op(8'h1a, arr(9'h046), 8'h3c);
        rdc("prog sel", arr(9'h046), 8'h3c);
        rdc("prog sel nb", arr(9'h047), ERASED_BYTE);
        op(8'h02, arr(9'h047), 8'h77);
        op(8'h02, arr(9'h052), 8'h11);
        op(8'h16, arr(9'h045), 8'h00);
        rdc("byte erase", arr(9'h045), ERASED_BYTE);
        rdc("byte erase nb", arr(9'h046), 8'h3c);
        op(8'h0e, arr(9'h05a), 8'h00);
        rdc("row erase", arr(9'h052), ERASED_BYTE);
        rdc("row erase nb", arr(9'h047), 8'h77);
        op(8'h1e, arr(9'h046), 8'h00);
        rdc("byte row", arr(9'h046), ERASED_BYTE);
        rdc("byte row nb", arr(9'h047), 8'h77);
        wr(CTL, 8'h06);
        wr(CTL, 8'h07);
        wr(CTL, 8'h00);
        rdc("no target", arr(9'h047), 8'h77);
        wr(CTL, 8'h02);
        wr(arr(9'h060), 8'h12);
        wr(CTL, 8'h03);
        wr(arr(9'h061), 8'h00);
        wr(CTL, 8'h00);
        rdc("hv target", arr(9'h060), 8'h12);
        rdc("hv ignored", arr(9'h061), ERASED_BYTE);
        wr(arr(9'h062), 8'h00);
        rdc("rom write", arr(9'h062), ERASED_BYTE);
        $display("test erase and program done");
        foreach (offs[i]) op(8'h02, arr(offs[i]), 8'h00);
        wr(BP, 8'h02);
        foreach (offs[i]) op(8'h16, arr(offs[i]), 8'h00);
        foreach (offs[i]) rdc("blk1", arr(offs[i]),
                              (i == 1 || i == 2) ? 8'h00 : ERASED_BYTE);
        foreach (offs[i]) op(8'h02, arr(offs[i]), 8'h00);
        wr(BP, 8'h1f);
        op(8'h06, arr(9'h100), 8'h00);
        foreach (offs[i]) rdc("all blk", arr(offs[i]), 8'h00);
        while (cyc < WIN + 4) @(posedge clk);
        wr(BP, 8'h00);
        rdc("protect late", BP, 8'h1f);
        $display("test protection done");
        do_reset();
        rdc("protect rst", BP, 8'(BLOCK_PROTECT_CTL_RESET));
        wr(BP, 8'h00);
        op(8'h16, OPT, 8'h00);
        op(8'h02, OPT, 8'hf5);
        wr(OPT, 8'h00);
        rdc("opt pending", OPT, CFG_RESET);
        wr(BP, 8'h10);
        op(8'h16, OPT, 8'h00);
        do_reset();
        rdc("opt new", OPT, 8'hf5);
        wr(BP, 8'h00);
        op(8'h06, OPT, 8'h00);
        foreach (offs[i]) rdc("bulk opt", arr(offs[i]), ERASED_BYTE);
        special_mode <= 1'b1;
        do_reset();
        rdc("opt erased", OPT, ERASED_BYTE);
        while (cyc < WIN + 4) @(posedge clk);
        wr(BP, 8'h00);
        rdc("protect special", BP, 8'h00);
        $display("test option cell done");
        print_verdict();
    end
endmodule : eeprom_program_erase_ctrl_bench
`default_nettype wire
